// ### pkg/fspc_pkg.sv
package fspc_pkg;

    // register word offsets (byte addresses on the bus)
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_KEY   = 8'h04;
    localparam logic [7:0] OFS_PAGE  = 8'h08;
    localparam logic [7:0] OFS_EA    = 8'h0C;
    localparam logic [7:0] OFS_LOW   = 8'h10;
    localparam logic [7:0] OFS_HIGH  = 8'h14;

    // control field positions
    localparam int CTL_START_BIT = 15;
    localparam int CTL_EN_BIT    = 14;
    localparam int CTL_ERR_BIT   = 13;
    localparam int CTL_ERASE_BIT = 6;
    localparam int CTL_OP_LSB    = 0;
    localparam int CFG_SPACE_BIT = 7;

    // reset values
    localparam logic [15:0] CTL_RESET  = 16'h0000;
    localparam logic [7:0]  PAGE_RESET = 8'h00;
    localparam logic [15:0] EA_RESET   = 16'h0000;

    // unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // array geometry: ROW_WORDS in instructions, the masks in program address units (two per instruction)
    localparam int          ROW_WORDS  = 64;
    localparam int          PAGE_ROWS  = 8;
    localparam logic [23:0] ROW_MASK   = 24'hFFFF80;
    localparam logic [23:0] PAGE_MASK  = 24'hFFFC00;

    // operation codes
    localparam logic [3:0] OP_BULK    = 4'hF;
    localparam logic [3:0] OP_SEG_GEN = 4'hD;
    localparam logic [3:0] OP_SEG_SEC = 4'hC;
    localparam logic [3:0] OP_RSV_E   = 4'hE;
    localparam logic [3:0] OP_RSV_B   = 4'hB;
    localparam logic [3:0] OP_WORD    = 4'h3;
    localparam logic [3:0] OP_PAGE    = 4'h2;
    localparam logic [3:0] OP_ROW     = 4'h1;
    localparam logic [3:0] OP_CFG     = 4'h0;

    // self-timed operation length
    localparam int CLK_HZ     = 40_000_000;
    localparam int OP_TIME_US = 4000;
    localparam int OP_CYCLES  = (CLK_HZ / 1_000_000) * OP_TIME_US;

    typedef enum logic [3:0] {
        K_NONE, K_BULK, K_SEG_GEN, K_SEG_SEC, K_PAGE_ERASE, K_CFG_ERASE,
        K_WORD, K_ROW, K_CFG_PROG, K_BAD
    } fspc_kind_e;

    typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_OPEN} fspc_key_e;

    typedef enum logic [1:0] {S_IDLE, S_LOAD, S_WAIT} fspc_state_e;

    typedef struct packed {
        logic        we;
        logic        erase;
        fspc_kind_e  kind;
        logic [23:0] addr;
        logic [23:0] data;
    } fspc_arr_s;

endpackage : fspc_pkg

// ### design/fspc_top.sv
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
module fspc_top #(
    parameter int ROW_WORDS = fspc_pkg::ROW_WORDS,
    parameter int OP_CYCLES = fspc_pkg::OP_CYCLES
) (
    // clock and resets
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire logic               sys_rst_i,
    // avalon-mm slave
    input  wire logic [7:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    input  wire logic [3:0]         avs_byteenable_i,
    output logic      [31:0]        avs_readdata_o,
    output logic                    avs_waitrequest_o,
    // flash array
    output fspc_pkg::fspc_arr_s     arr_cmd_o,
    output logic      [23:0]        arr_raddr_o,
    input  wire logic [23:0]        arr_rdata_i,
    output logic                    cfg_space_o,
    output logic                    busy_o
);

    localparam int IW = $clog2(ROW_WORDS);
    localparam int TW = $clog2(OP_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic                   ctl_start;
    logic                   ctl_en;
    logic                   ctl_err;
    logic                   ctl_erase;
    logic [3:0]             ctl_op;
    fspc_pkg::fspc_key_e    key_st;
    logic [7:0]             page;
    logic [15:0]            ea;
    logic [23:0]            latch [ROW_WORDS];
    fspc_pkg::fspc_state_e  state;
    logic [IW-1:0]          idx;
    logic [TW-1:0]          tmr;
    logic [23:0]            seq_addr;
    logic                   ack_q;

    logic                   req;
    logic                   wr;
    logic                   rd;
    logic [23:0]            tbl_addr;
    logic [IW-1:0]          tbl_idx;
    logic                   start_try;
    logic                   next_en;
    logic                   next_erase;
    logic [3:0]             next_op;
    fspc_pkg::fspc_kind_e   kind;
    logic                   launch;
    logic                   bad;
    logic                   done;
    logic                   abort;
    logic [31:0]            next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // operation decode

    function automatic fspc_pkg::fspc_kind_e decode(input logic erase, input logic [3:0] op);
        fspc_pkg::fspc_kind_e k;
        k = fspc_pkg::K_BAD;
        if (erase) begin
            case (op)
                fspc_pkg::OP_BULK:    k = fspc_pkg::K_BULK;
                fspc_pkg::OP_SEG_GEN: k = fspc_pkg::K_SEG_GEN;
                fspc_pkg::OP_SEG_SEC: k = fspc_pkg::K_SEG_SEC;
                fspc_pkg::OP_PAGE:    k = fspc_pkg::K_PAGE_ERASE;
                fspc_pkg::OP_CFG:     k = fspc_pkg::K_CFG_ERASE;
                fspc_pkg::OP_WORD:    k = fspc_pkg::K_NONE;
                fspc_pkg::OP_ROW:     k = fspc_pkg::K_NONE;
                default:              k = fspc_pkg::K_BAD;
            endcase
        end else begin
            case (op)
                fspc_pkg::OP_WORD:    k = fspc_pkg::K_WORD;
                fspc_pkg::OP_ROW:     k = fspc_pkg::K_ROW;
                fspc_pkg::OP_CFG:     k = fspc_pkg::K_CFG_PROG;
                fspc_pkg::OP_BULK:    k = fspc_pkg::K_NONE;
                fspc_pkg::OP_SEG_GEN: k = fspc_pkg::K_NONE;
                fspc_pkg::OP_SEG_SEC: k = fspc_pkg::K_NONE;
                fspc_pkg::OP_PAGE:    k = fspc_pkg::K_NONE;
                default:              k = fspc_pkg::K_BAD;
            endcase
        end
        return k;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, held off entirely while busy

    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_q;
    assign wr                = avs_write_i & ack_q;
    assign rd                = avs_read_i & ack_q;
    assign busy_o            = (state != fspc_pkg::S_IDLE);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q & ~busy_o;
        end
    end

    assign tbl_addr    = {page, ea};
    assign tbl_idx     = ea[IW:1];
    assign arr_raddr_o = tbl_addr;
    assign cfg_space_o = page[fspc_pkg::CFG_SPACE_BIT];

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (avs_address_i)
            fspc_pkg::OFS_CTRL: begin
                next_rdata[fspc_pkg::CTL_START_BIT] = ctl_start;
                next_rdata[fspc_pkg::CTL_EN_BIT]    = ctl_en;
                next_rdata[fspc_pkg::CTL_ERR_BIT]   = ctl_err;
                next_rdata[fspc_pkg::CTL_ERASE_BIT] = ctl_erase;
                next_rdata[fspc_pkg::CTL_OP_LSB +: 4] = ctl_op;
            end
            fspc_pkg::OFS_PAGE: next_rdata[7:0]  = page;
            fspc_pkg::OFS_EA:   next_rdata[15:0] = ea;
            fspc_pkg::OFS_LOW:  next_rdata[15:0] = arr_rdata_i[15:0];
            fspc_pkg::OFS_HIGH: next_rdata[7:0]  = arr_rdata_i[23:16];
            default:            next_rdata = 32'h0000_0000;
        endcase
    end

    // key reads back zero, being write-only
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            avs_readdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start request evaluation

    assign start_try  = wr && avs_address_i == fspc_pkg::OFS_CTRL && avs_byteenable_i[1]
                        && avs_writedata_i[fspc_pkg::CTL_START_BIT];
    assign next_en    = avs_byteenable_i[1] ? avs_writedata_i[fspc_pkg::CTL_EN_BIT] : ctl_en;
    assign next_erase = avs_byteenable_i[0] ? avs_writedata_i[fspc_pkg::CTL_ERASE_BIT]
                                            : ctl_erase;
    assign next_op    = avs_byteenable_i[0] ? avs_writedata_i[fspc_pkg::CTL_OP_LSB +: 4]
                                            : ctl_op;
    assign kind       = decode(next_erase, next_op);
    // no-op codes are accepted quietly; reserved ones are a sequence error
    assign launch     = start_try && key_st == fspc_pkg::KEY_OPEN && next_en
                        && kind != fspc_pkg::K_BAD && kind != fspc_pkg::K_NONE;
    assign bad        = start_try && !(key_st == fspc_pkg::KEY_OPEN && next_en
                        && kind != fspc_pkg::K_BAD);
    assign done       = state == fspc_pkg::S_WAIT && tmr == TW'(1);
    assign abort      = sys_rst_i && busy_o;

    ////////////////////////////////////////////////////////////////////////////
    // control register: only the power-on reset clears EN, ERASE and OP; a sys_rst_i abort also clears START

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ctl_en    <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_EN_BIT];
            ctl_erase <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_ERASE_BIT];
            ctl_op    <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_OP_LSB +: 4];
        end else if (wr && avs_address_i == fspc_pkg::OFS_CTRL) begin
            ctl_en    <= next_en;
            ctl_erase <= next_erase;
            ctl_op    <= next_op;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ctl_err <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_ERR_BIT];
        end else if (bad || abort) begin
            ctl_err <= 1'b1;
        end else if (wr && avs_address_i == fspc_pkg::OFS_CTRL && avs_byteenable_i[1]) begin
            ctl_err <= avs_writedata_i[fspc_pkg::CTL_ERR_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ctl_start <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_START_BIT];
        end else if (launch) begin
            ctl_start <= 1'b1;
        end else if (done || abort) begin
            ctl_start <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock key: one 0x55, 0xAA pair arms exactly one following write

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || sys_rst_i) begin
            key_st <= fspc_pkg::KEY_NONE;
        end else if (wr) begin
            if (avs_address_i == fspc_pkg::OFS_KEY && avs_byteenable_i[0]) begin
                if (avs_writedata_i[7:0] == fspc_pkg::KEY_FIRST) begin
                    key_st <= fspc_pkg::KEY_HALF;
                end else if (avs_writedata_i[7:0] == fspc_pkg::KEY_SECOND
                             && key_st == fspc_pkg::KEY_HALF) begin
                    key_st <= fspc_pkg::KEY_OPEN;
                end else begin
                    key_st <= fspc_pkg::KEY_NONE;
                end
            end else begin
                key_st <= fspc_pkg::KEY_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // table pointer and holding latches

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            page <= fspc_pkg::PAGE_RESET;
            ea   <= fspc_pkg::EA_RESET;
        end else if (wr) begin
            if (avs_address_i == fspc_pkg::OFS_PAGE && avs_byteenable_i[0]) begin
                page <= avs_writedata_i[7:0];
            end
            if (avs_address_i == fspc_pkg::OFS_EA) begin
                if (avs_byteenable_i[0]) ea[7:0]  <= avs_writedata_i[7:0];
                if (avs_byteenable_i[1]) ea[15:8] <= avs_writedata_i[15:8];
            end
        end
    end

    // latches hold no reset: their content is only meaningful after loading
    always_ff @(posedge clk_sys_i) begin
        if (wr && avs_address_i == fspc_pkg::OFS_LOW) begin
            if (avs_byteenable_i[0]) latch[tbl_idx][7:0]  <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1]) latch[tbl_idx][15:8] <= avs_writedata_i[15:8];
        end
        if (wr && avs_address_i == fspc_pkg::OFS_HIGH && avs_byteenable_i[0]) begin
            latch[tbl_idx][23:16] <= avs_writedata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operation sequencer

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state     <= fspc_pkg::S_IDLE;
            idx       <= '0;
            tmr       <= '0;
            seq_addr  <= 24'h000000;
            arr_cmd_o <= '0;
        end else if (abort) begin
            state     <= fspc_pkg::S_IDLE;
            arr_cmd_o <= '0;
        end else begin
            arr_cmd_o.we    <= 1'b0;
            arr_cmd_o.erase <= 1'b0;
            case (state)
                fspc_pkg::S_IDLE: begin
                    if (launch) begin
                        tmr            <= TW'(OP_CYCLES);
                        arr_cmd_o.kind <= kind;
                        state          <= fspc_pkg::S_WAIT;
                        case (kind)
                            fspc_pkg::K_ROW: begin
                                idx      <= '0;
                                seq_addr <= tbl_addr & fspc_pkg::ROW_MASK;
                                state    <= fspc_pkg::S_LOAD;
                            end
                            fspc_pkg::K_WORD: begin
                                arr_cmd_o.we   <= 1'b1;
                                arr_cmd_o.addr <= {tbl_addr[23:1], 1'b0};
                                arr_cmd_o.data <= latch[tbl_idx];
                            end
                            fspc_pkg::K_CFG_PROG: begin
                                arr_cmd_o.we   <= 1'b1;
                                arr_cmd_o.addr <= tbl_addr;
                                arr_cmd_o.data <= {16'h0000, latch[tbl_idx][7:0]};
                            end
                            fspc_pkg::K_PAGE_ERASE: begin
                                arr_cmd_o.erase <= 1'b1;
                                arr_cmd_o.addr  <= tbl_addr & fspc_pkg::PAGE_MASK;
                            end
                            default: begin
                                arr_cmd_o.erase <= 1'b1;
                                arr_cmd_o.addr  <= tbl_addr;
                            end
                        endcase
                    end
                end
                fspc_pkg::S_LOAD: begin
                    arr_cmd_o.we   <= 1'b1;
                    arr_cmd_o.addr <= seq_addr + {{(23-IW){1'b0}}, idx, 1'b0};
                    arr_cmd_o.data <= latch[idx];
                    idx            <= idx + 1'b1;
                    if (idx == IW'(ROW_WORDS - 1)) begin
                        state <= fspc_pkg::S_WAIT;
                    end
                end
                fspc_pkg::S_WAIT: begin
                    tmr <= tmr - 1'b1;
                    if (tmr == TW'(1)) begin
                        state <= fspc_pkg::S_IDLE;
                    end
                end
                default: state <= fspc_pkg::S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_start_needs_key: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(ctl_start) |-> $past(key_st) == fspc_pkg::KEY_OPEN
        && ctl_en)
        else $error("operation started without unlock or enable");

    a_busy_stall_bus: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        busy_o && req |-> avs_waitrequest_o)
        else $error("bus answered while an operation ran");

    a_start_holds: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i || sys_rst_i)
        $rose(ctl_start) |-> ctl_start [*8])
        else $error("start bit dropped too early");

    a_bare_start_err: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        start_try && key_st != fspc_pkg::KEY_OPEN |=> ctl_err && !ctl_start)
        else $error("start without unlock not flagged");

    a_disabled_no_array: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        start_try && !next_en && !busy_o |=> !arr_cmd_o.we && !arr_cmd_o.erase ##1
        !arr_cmd_o.we && !arr_cmd_o.erase)
        else $error("array touched by a refused start");

    a_key_cancel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        wr && avs_address_i != fspc_pkg::OFS_KEY |=> key_st == fspc_pkg::KEY_NONE)
        else $error("unlock survived an unrelated write");

    a_ctl_unused_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rd && avs_address_i == fspc_pkg::OFS_CTRL |->
        avs_readdata_o[12:7] == 6'h00 && avs_readdata_o[5:4] == 2'h0
        && avs_readdata_o[31:16] == 16'h0000)
        else $error("unimplemented control bits read nonzero");

    a_row_word_count: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i || sys_rst_i)
        $fell(state == fspc_pkg::S_LOAD) |-> $past(idx) == IW'(ROW_WORDS - 1)
        && state == fspc_pkg::S_WAIT)
        else $error("row program did not write the full row");

    a_page_aligned: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        arr_cmd_o.erase && arr_cmd_o.kind == fspc_pkg::K_PAGE_ERASE |->
        arr_cmd_o.addr[9:0] == 10'h000)
        else $error("page erase address not page aligned");

endmodule : fspc_top

// ### bench/fspc_flash_model.sv
`timescale 1ns/1ps
module fspc_flash_model (
    // clock and commands
    input  wire logic                clk_sys_i,
    input  wire fspc_pkg::fspc_arr_s arr_cmd_i,
    // read port
    input  wire logic [23:0]         arr_raddr_i,
    output logic      [23:0]         arr_rdata_o
);
    // only 4096 words modelled, higher pages and config space alias onto them
    logic [23:0] mem [4096];
    initial begin
        foreach (mem[k]) mem[k] = 24'hFFFFFF;
    end
    assign arr_rdata_o = mem[arr_raddr_i[12:1]];
    ////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        if (arr_cmd_i.we) begin
            mem[arr_cmd_i.addr[12:1]] <= arr_cmd_i.data;
        end
        if (arr_cmd_i.erase && arr_cmd_i.kind == fspc_pkg::K_PAGE_ERASE) begin
            for (int k = 0; k < 512; k++) mem[{arr_cmd_i.addr[12:10], 9'h0} + k] <= 24'hFFFFFF;
        end
        if (arr_cmd_i.erase && arr_cmd_i.kind inside {fspc_pkg::K_BULK, fspc_pkg::K_SEG_GEN,
                                                      fspc_pkg::K_SEG_SEC}) begin
            foreach (mem[k]) mem[k] <= 24'hFFFFFF;
        end
    end
endmodule : fspc_flash_model

// ### bench/tb_flash_self_program_control.sv
`timescale 1ns/1ps
module tb_flash_self_program_control;
    logic                clk_sys_i, rstn_i, sys_rst_i, avs_read_i, avs_write_i;
    logic                avs_waitrequest_o, cfg_space_o, busy_o;
    logic [7:0]          avs_address_i;
    logic [3:0]          avs_byteenable_i;
    logic [31:0]         avs_writedata_i, avs_readdata_o;
    logic [23:0]         arr_raddr_o, arr_rdata_i;
    fspc_pkg::fspc_arr_s arr_cmd_o;
    logic [31:0]         exp_q[$];
    logic [23:0]         lat[64];
    logic [15:0]         ctl_v;
    logic                ok;
    int                  error_cnt, checks_done, cyc, i, c;

    fspc_top #(.ROW_WORDS(64), .OP_CYCLES(20)) dut (.clk_sys_i, .rstn_i, .sys_rst_i,
        .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
        .avs_readdata_o, .avs_waitrequest_o, .arr_cmd_o, .arr_raddr_o, .arr_rdata_i,
        .cfg_space_o, .busy_o);
    fspc_flash_model model (.clk_sys_i, .arr_cmd_i(arr_cmd_o), .arr_raddr_i(arr_raddr_o),
        .arr_rdata_o(arr_rdata_i));
    ////////////////////////////////////////
    task automatic final_report();
        if (exp_q.size() != 0) error_cnt++;
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // request held until waitrequest is seen low, released one edge later
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clk_sys_i);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic op(input logic [15:0] ctl);
        bus(1'b1, fspc_pkg::OFS_KEY, 32'(fspc_pkg::KEY_FIRST));
        bus(1'b1, fspc_pkg::OFS_KEY, 32'(fspc_pkg::KEY_SECOND));
        bus(1'b1, fspc_pkg::OFS_CTRL, 32'(ctl));
    endtask : op
    ////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
            cmp(avs_readdata_o, exp_q.pop_front());
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        {rstn_i, sys_rst_i, avs_read_i, avs_write_i} = 4'h0;
        {avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
        {error_cnt, checks_done, cyc} = '0;
        void'($urandom(32'hA869948F));
        repeat (2) @(posedge clk_sys_i);
        rstn_i           <= 1'b1;
        avs_byteenable_i <= 4'hF;
        @(posedge clk_sys_i);
        rd(fspc_pkg::OFS_CTRL, 32'h0);
        rd(fspc_pkg::OFS_KEY, 32'h0);
        rd(8'h1C, 32'h0);
        ctl_v = 16'($urandom) & 16'h604F;
        bus(1'b1, fspc_pkg::OFS_CTRL, 32'(ctl_v) | 32'hFFFF1FB0);
        rd(fspc_pkg::OFS_CTRL, 32'(ctl_v));
        sys_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(fspc_pkg::OFS_CTRL, 32'(ctl_v));
        c = $urandom;
        bus(1'b1, fspc_pkg::OFS_PAGE, 32'h85);
        bus(1'b1, fspc_pkg::OFS_EA, 32'(c[15:0]));
        cmp(32'(arr_raddr_o), {8'h0, 8'h85, c[15:0]});
        cmp(32'(cfg_space_o), 32'h1);
        bus(1'b1, fspc_pkg::OFS_PAGE, 32'h0);
        cmp(32'(cfg_space_o), 32'h0);
        for (i = 0; i < 64; i++) begin
            lat[i] = 24'($urandom);
            bus(1'b1, fspc_pkg::OFS_EA, 32'h600 + 32'(2 * i));
            bus(1'b1, fspc_pkg::OFS_LOW, 32'(lat[i][15:0]));
            bus(1'b1, fspc_pkg::OFS_HIGH, 32'(lat[i][23:16]));
        end
        op(16'hC001);
        cmp(32'(busy_o), 32'h1);
        rd(fspc_pkg::OFS_CTRL, 32'h4001);
        for (i = 0; i < 64; i++) begin
            bus(1'b1, fspc_pkg::OFS_EA, 32'h600 + 32'(2 * i));
            rd(fspc_pkg::OFS_LOW, 32'(lat[i][15:0]));
            rd(fspc_pkg::OFS_HIGH, 32'(lat[i][23:16]));
        end
        bus(1'b1, fspc_pkg::OFS_CTRL, 32'hC003);
        rd(fspc_pkg::OFS_CTRL, 32'h6003);
        bus(1'b1, fspc_pkg::OFS_KEY, 32'(fspc_pkg::KEY_FIRST));
        bus(1'b1, fspc_pkg::OFS_PAGE, 32'h0);
        bus(1'b1, fspc_pkg::OFS_KEY, 32'(fspc_pkg::KEY_SECOND));
        bus(1'b1, fspc_pkg::OFS_CTRL, 32'hC003);
        rd(fspc_pkg::OFS_CTRL, 32'h6003);
        op(16'h8003);
        rd(fspc_pkg::OFS_CTRL, 32'h2003);
        rd(fspc_pkg::OFS_LOW, 32'(lat[63][15:0]));
        op(16'hC042);
        rd(fspc_pkg::OFS_CTRL, 32'h4042);
        rd(fspc_pkg::OFS_LOW, 32'hFFFF);
        // terminate a running erase: start drops, error flag rises
        op(16'hC042);
        sys_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(fspc_pkg::OFS_CTRL, 32'h6042);
        for (c = 0; c < 32; c++) begin
            ok = c[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD, 4'hF};
            op({3'b110, 6'h0, c[4], 2'b00, c[3:0]});
            rd(fspc_pkg::OFS_CTRL, {16'h0, 2'b01, ~ok, 6'h0, c[4], 2'b00, c[3:0]});
        end
        repeat (4) @(posedge clk_sys_i);
        final_report();
    end
endmodule : tb_flash_self_program_control
